// File: scgc_ctrl.sv
/*
 sleep and clock gating controller: ahb-lite register slave, sleep state
 machine with wake latency, and glitch-free clock enables per domain.
 assumes the cpu pulses sleep_exec for one cycle per sleep instruction,
 wake sources arrive asynchronously, and gating cells are latch-free ands.
*/
// Contract
// - sleep only when enable set at sleep
// - mode codes 000 idle, 010/110 deep
// - interrupt wake halts cpu four more cycles
// - register file and sram untouched
// - reset while asleep restarts from vector
// - idle stops only cpu and flash clocks
// - idle wakes on external or internal irq
// - power-down stops oscillator and generated clocks
// - power-down wakes only on listed events
// - power-down wake waits 32000 clocks
// - standby keeps oscillator, wakes in six
// - deep sleep takes only level irq zero
// - gated peripheral frozen, registers blocked
// - gate register resets to zero
// - bit 7 stops two-wire clock
// - bit 5 freezes timer zero
// - bit 3 freezes timer one
// - bit 1 stops uart zero clock
`timescale 1ns/1ps
`default_nettype none
module scgc_ctrl
   import scgc_pkg::*;
#(
   parameter int PDOWN_WAKE_CYCLES = SCGC_PDOWN_WAKE_CK
)(
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     clk_en,
   input  wire scgc_pkg::scgc_ahb_req_s  ahb_req,
   input  wire logic [31:0]              hwdata,
   output logic [31:0]                   hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   input  wire logic                     sleep_exec,
   input  wire logic                     irq_pending,
   input  wire logic                     external_irq_zero,
   input  wire logic                     irq_zero_level_mode,
   input  wire logic                     async_wake,
   output logic                          cpu_resume,
   output logic                          irq_service,
   output var scgc_pkg::scgc_gate_s      gate_en,
   output logic                          periph_access_block_twi,
   output logic                          periph_access_block_tim0,
   output logic                          periph_access_block_tim1,
   output logic                          periph_access_block_uart0
);
   import scgc_pkg::*;

   // ==========================================================
   // registers and state
   logic [7:0]  sleep_mode_control_reg;
   logic [7:0]  peripheral_clock_gate_0_reg;
   scgc_state_e state_reg;
   logic [15:0] wait_cnt_reg;
   logic        wr_pend_reg;
   logic [31:0] wr_addr_reg;
   logic [31:0] rdata_next;
   logic [1:0]  irq0_sync_reg;
   logic [1:0]  async_sync_reg;
   logic        sleep_enable;
   logic [2:0]  sleep_mode_select;
   logic        deep_wake;
   logic        idle_wake;
   scgc_gate_s  gate_next;
   scgc_gate_s  gate_rise_reg;
   scgc_gate_s  gate_at_rise_reg;
   logic [15:0] wake_len_reg;
   scgc_state_e last_sleep_reg;

   assign sleep_enable      = sleep_mode_control_reg[SCGC_SLEEP_EN_BIT];
   assign sleep_mode_select = sleep_mode_control_reg[SCGC_SM_LSB +: 3];

   // decode used by the status read and by the checks
   function automatic logic mode_valid(input logic [2:0] m);
      mode_valid = (m == SCGC_SM_IDLE) || (m == SCGC_SM_PDOWN) || (m == SCGC_SM_STANDBY);
   endfunction

   // ==========================================================
   // bus slave: always zero wait, okay response
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h00000000;
      end else if (clk_en) begin
         wr_pend_reg <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hwrite && ahb_req.hready;
         wr_addr_reg <= ahb_req.haddr;
      end
   end

   // read mux, latched at address phase so data stands in the data phase
   always_comb begin
      rdata_next = 32'h00000000;
      if (ahb_req.haddr == SCGC_ADDR_SMC) begin
         rdata_next = {24'h000000, sleep_mode_control_reg & SCGC_SMC_MASK};
      end else if (ahb_req.haddr == SCGC_ADDR_PCG0) begin
         rdata_next = {24'h000000, peripheral_clock_gate_0_reg};
      end else if (ahb_req.haddr == SCGC_ADDR_STATUS) begin
         rdata_next = {27'h0000000, mode_valid(sleep_mode_select), 1'b0, state_reg};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (clk_en && ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
         hrdata <= rdata_next;
      end
   end

   // sleep control register; only bits 3..0 are writable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_mode_control_reg <= SCGC_SMC_RESET;
      end else if (clk_en && wr_pend_reg && wr_addr_reg == SCGC_ADDR_SMC) begin
         sleep_mode_control_reg <= hwdata[7:0] & SCGC_SMC_MASK;
      end
   end

   // gate register starts with every peripheral clocked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         peripheral_clock_gate_0_reg <= SCGC_PCG0_RESET;
      end else if (clk_en && wr_pend_reg && wr_addr_reg == SCGC_ADDR_PCG0) begin
         peripheral_clock_gate_0_reg <= hwdata[7:0] & SCGC_PCG0_MASK;
      end
   end

   // ==========================================================
   // wake sources from pins pass two flops first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq0_sync_reg  <= 2'b00;
         async_sync_reg <= 2'b00;
      end else begin
         irq0_sync_reg  <= {irq0_sync_reg[0], external_irq_zero};
         async_sync_reg <= {async_sync_reg[0], async_wake};
      end
   end

   // level irq zero only; edge forms need the stopped clock
   assign deep_wake = (irq0_sync_reg[1] && irq_zero_level_mode) || async_sync_reg[1];
   assign idle_wake = irq_pending || deep_wake;

   // ==========================================================
   // sleep state machine; hresetn here is any system reset, so a reset in
   // sleep simply returns to run and the cpu fetches its reset vector
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg    <= SCGC_RUN;
         wait_cnt_reg <= 16'h0000;
      end else if (clk_en) begin
         case (state_reg)
            SCGC_RUN: begin
               if (sleep_exec && sleep_enable) begin
                  if (sleep_mode_select == SCGC_SM_IDLE) begin
                     state_reg <= SCGC_IDLE;
                  end else if (sleep_mode_select == SCGC_SM_PDOWN) begin
                     state_reg <= SCGC_PDOWN;
                  end else if (sleep_mode_select == SCGC_SM_STANDBY) begin
                     state_reg <= SCGC_STANDBY;
                  end
               end
            end
            SCGC_IDLE: begin
               if (idle_wake) begin
                  state_reg    <= SCGC_HALT;
                  wait_cnt_reg <= SCGC_HALT_CNT - 16'h0001;
               end
            end
            SCGC_PDOWN: begin
               if (deep_wake) begin
                  state_reg    <= SCGC_STARTUP;
                  wait_cnt_reg <= 16'(PDOWN_WAKE_CYCLES - 1);
               end
            end
            SCGC_STANDBY: begin
               if (deep_wake) begin
                  state_reg    <= SCGC_STARTUP;
                  wait_cnt_reg <= SCGC_STBY_CNT - SCGC_HALT_CNT - 16'h0001;
               end
            end
            SCGC_STARTUP: begin
               if (wait_cnt_reg == 16'h0000) begin
                  state_reg    <= SCGC_HALT;
                  wait_cnt_reg <= SCGC_HALT_CNT - 16'h0001;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg - 16'h0001;
               end
            end
            SCGC_HALT: begin
               if (wait_cnt_reg == 16'h0000) begin
                  state_reg <= SCGC_RUN;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg - 16'h0001;
               end
            end
            default: begin
               state_reg <= SCGC_RUN;
            end
         endcase
      end
   end

   // one-cycle pulse: cpu leaves halt, takes the vector, then returns
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_resume  <= 1'b0;
         irq_service <= 1'b0;
      end else if (clk_en) begin
         cpu_resume  <= (state_reg == SCGC_HALT) && (wait_cnt_reg == 16'h0000);
         irq_service <= (state_reg == SCGC_HALT) && (wait_cnt_reg == 16'h0000);
      end else begin
         cpu_resume  <= 1'b0;
         irq_service <= 1'b0;
      end
   end

   // ==========================================================
   // domain enables; memories only lose their clock, never their contents
   always_comb begin
      gate_next.cpu   = (state_reg == SCGC_RUN);
      gate_next.flash = (state_reg == SCGC_RUN);
      gate_next.io    = (state_reg == SCGC_RUN) || (state_reg == SCGC_IDLE)
                        || (state_reg == SCGC_HALT);
      gate_next.osc   = (state_reg != SCGC_PDOWN);
      gate_next.twi   = gate_next.io && !peripheral_clock_gate_0_reg[SCGC_TWI_BIT];
      gate_next.tim0  = gate_next.io && !peripheral_clock_gate_0_reg[SCGC_TIM0_BIT];
      gate_next.tim1  = gate_next.io && !peripheral_clock_gate_0_reg[SCGC_TIM1_BIT];
      gate_next.uart0 = gate_next.io && !peripheral_clock_gate_0_reg[SCGC_UART0_BIT];
   end

   // staged on the rising edge, moved to the output on the falling edge so
   // the and gate only sees a change while the clock is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_rise_reg <= '1;
      end else begin
         gate_rise_reg <= gate_next;
      end
   end

   always_ff @(negedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_en <= '1;
      end else begin
         gate_en <= gate_rise_reg;
      end
   end

   // register access to a gated peripheral is refused
   assign periph_access_block_twi   = !gate_en.twi;
   assign periph_access_block_tim0  = !gate_en.tim0;
   assign periph_access_block_tim1  = !gate_en.tim1;
   assign periph_access_block_uart0 = !gate_en.uart0;

   // ==========================================================
   // check helpers; they feed only the assertions below and carry no
   // behaviour of their own, so synthesis may drop them

   // gate value as it stood just before each rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_at_rise_reg <= '1;
      end else begin
         gate_at_rise_reg <= gate_en;
      end
   end

   // edges spent in startup and halt; frozen along with the fsm so the
   // figure stays in fsm cycles even when the clock enable drops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_len_reg <= 16'h0000;
      end else if (clk_en) begin
         if (state_reg == SCGC_STARTUP || state_reg == SCGC_HALT) begin
            wake_len_reg <= wake_len_reg + 16'h0001;
         end else begin
            wake_len_reg <= 16'h0000;
         end
      end
   end

   // sleep state that the current wake started from
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_sleep_reg <= SCGC_RUN;
      end else if (clk_en) begin
         if (state_reg == SCGC_IDLE || state_reg == SCGC_PDOWN
             || state_reg == SCGC_STANDBY) begin
            last_sleep_reg <= state_reg;
         end
      end
   end

   // ==========================================================
   // checks
   enter_needs_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_RUN && clk_en && !(sleep_exec && sleep_enable)) |=> state_reg == SCGC_RUN)
      else $error("sleep entered without sleep enable");
   reserved_noop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_RUN && clk_en && !mode_valid(sleep_mode_select)) |=> state_reg == SCGC_RUN)
      else $error("reserved mode left run");
   idle_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_RUN && clk_en && sleep_exec && sleep_enable
       && sleep_mode_select == SCGC_SM_IDLE) |=> state_reg == SCGC_IDLE)
      else $error("idle code did not enter idle");
   halt_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(state_reg == SCGC_HALT) && clk_en) |-> (state_reg == SCGC_HALT)[*4])
      else $error("halt shorter than four cycles");
   idle_clocks_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_IDLE) |=> (!gate_rise_reg.cpu && gate_rise_reg.io))
      else $error("idle gated wrong domains");
   pdown_osc_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_PDOWN) |=> !gate_rise_reg.osc)
      else $error("oscillator kept in power-down");
   deep_only_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_PDOWN && !deep_wake) |=> state_reg == SCGC_PDOWN)
      else $error("power-down left without deep wake");
   standby_six_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_STANDBY && deep_wake && clk_en) ##1 clk_en[*6] |-> ##1 cpu_resume)
      else $error("standby wake not in six cycles");
   twi_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      peripheral_clock_gate_0_reg[SCGC_TWI_BIT] |=> !gate_rise_reg.twi)
      else $error("two-wire clock not stopped");
   // at the falling edge the enable must still hold what it had before the
   // rising edge: any move in the high phase would clip a clock pulse
   gate_low_a: assert property (@(negedge hclk) disable iff (!hresetn)
      gate_en == gate_at_rise_reg)
      else $error("gate enable moved at rising edge");

   // wake latency held against the rule figures, not the counter loads
   idle_wake_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_HALT && wait_cnt_reg == 16'h0000
       && last_sleep_reg == SCGC_IDLE) |-> wake_len_reg == 16'(SCGC_HALT_CYCLES - 1))
      else $error("idle wake halt length wrong");
   pdown_wake_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_HALT && wait_cnt_reg == 16'h0000
       && last_sleep_reg == SCGC_PDOWN)
      |-> wake_len_reg == 16'(PDOWN_WAKE_CYCLES + SCGC_HALT_CYCLES - 1))
      else $error("power-down wake length wrong");
   stby_wake_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_HALT && wait_cnt_reg == 16'h0000
       && last_sleep_reg == SCGC_STANDBY) |-> wake_len_reg == 16'(SCGC_STANDBY_WAKE - 1))
      else $error("standby wake length wrong");
   idle_irq_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == SCGC_IDLE && irq_pending && clk_en) |=> state_reg == SCGC_HALT)
      else $error("pending irq did not wake idle");
   resume_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_resume |=> !cpu_resume)
      else $error("resume pulse longer than one cycle");

   idle_wake_c:  cover property (@(posedge hclk) state_reg == SCGC_IDLE ##1 state_reg == SCGC_HALT);
   pdown_wake_c: cover property (@(posedge hclk) state_reg == SCGC_PDOWN ##1 state_reg == SCGC_STARTUP);
   stby_wake_c:  cover property (@(posedge hclk) state_reg == SCGC_STANDBY ##1 state_reg == SCGC_STARTUP);
   gate_uart_c:  cover property (@(posedge hclk) !gate_en.uart0 ##1 gate_en.uart0);
   reserved_c:   cover property (@(posedge hclk) state_reg == SCGC_RUN && sleep_exec
                                 && sleep_enable && !mode_valid(sleep_mode_select));

endmodule
`default_nettype wire

// File: scgc_pkg.sv
/*
 sleep and clock gating control package: register indices, field positions,
 reset values, sleep mode codes, wake timing and the bus carrier structs.
 assumes a single 20 MHz system clock domain.
*/
package scgc_pkg;

   // ==========================================================
   // register map (printed offsets are indices, byte addr = 4 * index)
   localparam logic [7:0]  SCGC_IDX_SMC     = 8'h53;
   localparam logic [7:0]  SCGC_IDX_PCG0    = 8'h64;
   localparam logic [31:0] SCGC_ADDR_SMC    = 32'h0000014c;
   localparam logic [31:0] SCGC_ADDR_PCG0   = 32'h00000190;
   localparam logic [31:0] SCGC_ADDR_STATUS = 32'h00000200;
   localparam logic [7:0]  SCGC_SMC_RESET   = 8'h00;
   localparam logic [7:0]  SCGC_PCG0_RESET  = 8'h00;

   // ==========================================================
   // field positions
   localparam int SCGC_SLEEP_EN_BIT = 0;
   localparam int SCGC_SM_LSB       = 1;
   localparam int SCGC_TWI_BIT      = 7;
   localparam int SCGC_TIM0_BIT     = 5;
   localparam int SCGC_TIM1_BIT     = 3;
   localparam int SCGC_UART0_BIT    = 1;
   localparam logic [7:0] SCGC_SMC_MASK  = 8'h0f;
   localparam logic [7:0] SCGC_PCG0_MASK = 8'hff;

   // ==========================================================
   // sleep mode select encodings
   localparam logic [2:0] SCGC_SM_IDLE    = 3'h0;
   localparam logic [2:0] SCGC_SM_PDOWN   = 3'h2;
   localparam logic [2:0] SCGC_SM_STANDBY = 3'h6;

   // ==========================================================
   // timing, in clock cycles of the system clock
   localparam int SCGC_CLK_MHZ        = 20;
   localparam int SCGC_HALT_CYCLES    = 4;
   localparam int SCGC_PDOWN_WAKE_CK  = 32000;
   localparam int SCGC_STANDBY_WAKE   = 6;
   localparam logic [15:0] SCGC_HALT_CNT = 16'(SCGC_HALT_CYCLES);
   localparam logic [15:0] SCGC_STBY_CNT = 16'(SCGC_STANDBY_WAKE);

   typedef enum logic [2:0] {
      SCGC_RUN      = 3'b000,
      SCGC_IDLE     = 3'b001,
      SCGC_PDOWN    = 3'b010,
      SCGC_STANDBY  = 3'b011,
      SCGC_STARTUP  = 3'b100,
      SCGC_HALT     = 3'b101
   } scgc_state_e;

   // ahb-lite request carrier
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
   } scgc_ahb_req_s;

   // clock enables toward the gated domains
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic osc;
      logic twi;
      logic tim0;
      logic tim1;
      logic uart0;
   } scgc_gate_s;

endpackage

// File: scgc_cpu_model.sv
/*
 cpu side model for the sleep and clock gating controller: issues the
 one-cycle sleep pulse and counts resumes and resumes without an interrupt vector fetch.
 assumes the controller's hclk domain and its registered resume pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module scgc_cpu_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       do_sleep,
   input  wire logic       cpu_resume,
   input  wire logic       irq_service,
   output logic            sleep_exec,
   output logic [7:0]      resume_cnt,
   output logic [7:0]      vec_miss
);
   // ==========================================================
   // sleep instruction: software sets the enable just before it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_exec <= 1'b0;
      end else begin
         sleep_exec <= do_sleep;
      end
   end

   // a resume must fetch the interrupt vector in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resume_cnt <= 8'h00;
         vec_miss   <= 8'h00;
      end else if (cpu_resume === 1'b1) begin
         resume_cnt <= resume_cnt + 8'h01;
         if (irq_service !== 1'b1) begin
            vec_miss <= vec_miss + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: sleep_and_clock_gating_control_test.sv
/*
 testbench for the sleep and clock gating controller: register access,
 every mode code, wake latency and sources, gating, reset while asleep.
 assumes a zero-wait bus slave and a shortened power-down wake count.
*/
`timescale 1ns/1ps
`default_nettype none
module sleep_and_clock_gating_control_test;
   import scgc_pkg::*;
   localparam int PDW = 20;
   logic          hclk, hresetn, hsel, hwrite, do_sleep, sleep_exec, sleep_on, clk_en;
   logic          irq_pending, ext_irq, level_mode, async_wake;
   logic          hreadyout, hresp, cpu_resume, irq_service;
   logic          blk_twi, blk_t0, blk_t1, blk_u0;
   logic [1:0]    htrans;
   logic [2:0]    m;
   logic [7:0]    resume_cnt, vec_miss;
   logic [31:0]   haddr, hwdata, hrdata, rd, seed;
   scgc_ahb_req_s req;
   scgc_gate_s    gate_en;
   int            bad_count, tests_run;
   int            cycles = 0;

   assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hreadyout};

   scgc_ctrl #(.PDOWN_WAKE_CYCLES(PDW)) i_scgc_ctrl (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .ahb_req(req),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sleep_exec(sleep_exec), .irq_pending(irq_pending),
      .external_irq_zero(ext_irq), .irq_zero_level_mode(level_mode),
      .async_wake(async_wake), .cpu_resume(cpu_resume),
      .irq_service(irq_service), .gate_en(gate_en),
      .periph_access_block_twi(blk_twi), .periph_access_block_tim0(blk_t0),
      .periph_access_block_tim1(blk_t1), .periph_access_block_uart0(blk_u0));

   scgc_cpu_model i_scgc_cpu_model (
      .hclk(hclk), .hresetn(hresetn), .do_sleep(do_sleep),
      .cpu_resume(cpu_resume), .irq_service(irq_service),
      .sleep_exec(sleep_exec), .resume_cnt(resume_cnt), .vec_miss(vec_miss));

   // ==========================================================
   // helpers
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected {cpu,flash,io,osc}; reserved codes and a clear enable gate nothing
   function logic [31:0] exp_core(input logic [2:0] md, input logic en);
      if (!en) return 32'hf;
      case (md)
         SCGC_SM_IDLE:    return 32'h3;
         SCGC_SM_PDOWN:   return 32'h0;
         SCGC_SM_STANDBY: return 32'h1;
         default:         return 32'hf;
      endcase
   endfunction

   function logic [31:0] core_now();
      return {28'h0, gate_en.cpu, gate_en.flash, gate_en.io, gate_en.osc};
   endfunction

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // one single transfer; entered just after a rising edge
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task sleep_in(input logic [2:0] md, input logic en);
      ahb(1'b1, SCGC_ADDR_SMC, {28'h0, md, en});
      do_sleep <= 1'b1;
      @(posedge hclk);
      do_sleep <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask

   // source 0 irq, 1 async, 2 level mode on irq zero; resume in lo..hi cycles
   task wake(input int src, input int lo, input int hi);
      int n;
      n = 0;
      case (src)
         0: irq_pending <= 1'b1;
         1: async_wake <= 1'b1;
         default: level_mode <= 1'b1;
      endcase
      do begin
         @(posedge hclk);
         n++;
      end while (cpu_resume !== 1'b1 && n < 100);
      irq_pending <= 1'b0;
      async_wake <= 1'b0;
      level_mode <= 1'b0;
      ext_irq <= 1'b0;
      check({31'h0, n >= lo && n <= hi}, 32'h1);
      repeat (3) @(posedge hclk);
      ahb(1'b0, SCGC_ADDR_STATUS, 32'h0);
      check({25'h0, rd[2:0], gate_en.cpu, gate_en.flash, gate_en.io, gate_en.osc}, 32'hf);
   endtask

   // ==========================================================
   // clock and hang guard
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         test_done;
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      {hresetn, hsel, hwrite, do_sleep, irq_pending, ext_irq} = '0;
      {level_mode, async_wake, htrans, haddr, hwdata} = '0;
      clk_en = 1'b1;
      seed = 32'd93175;
      bad_count = 0;
      tests_run = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({24'h0, gate_en}, 32'hff);
      ahb(1'b0, SCGC_ADDR_SMC, 32'h0);
      check(rd, {24'h0, SCGC_SMC_RESET});
      ahb(1'b0, SCGC_ADDR_PCG0, 32'h0);
      check(rd, {24'h0, SCGC_PCG0_RESET});
      // unmapped place and read-only upper control bits
      ahb(1'b1, 32'h300, 32'hffffffff);
      ahb(1'b0, 32'h300, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, SCGC_ADDR_SMC, 32'hf0);
      ahb(1'b0, SCGC_ADDR_SMC, 32'h0);
      check(rd, 32'h0);
      // every mode code, then idle code with the enable clear
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         m = (i == 8) ? 3'h0 : i[2:0];
         sleep_on = (i < 8);
         // bench peripherals are idle, so gating them is safe
         ahb(1'b1, SCGC_ADDR_PCG0, {24'h0, seed[7:0]});
         ahb(1'b0, SCGC_ADDR_PCG0, 32'h0);
         check(rd, {24'h0, seed[7:0]});
         check({28'h0, blk_twi, blk_t0, blk_t1, blk_u0},
               {28'h0, seed[7], seed[5], seed[3], seed[1]});
         check({28'h0, gate_en.twi, gate_en.tim0, gate_en.tim1, gate_en.uart0},
               {28'h0, ~seed[7], ~seed[5], ~seed[3], ~seed[1]});
         sleep_in(m, sleep_on);
         check(core_now(), exp_core(m, sleep_on));
         if (exp_core(m, sleep_on) == 32'h3) wake(0, 4, 7);
         else if (exp_core(m, sleep_on) != 32'hf) begin
            irq_pending <= 1'b1;
            repeat (10) @(posedge hclk);
            check({31'h0, gate_en.cpu}, 32'h0);
            irq_pending <= 1'b0;
            // standby only under the crystal clock the bench stands for
            if (m == SCGC_SM_STANDBY) wake(1, 6, 10);
            else wake(1, PDW + 4, PDW + 10);
         end
      end
      // irq zero wakes deep sleep only in its level form
      // no pll or dcdc in the bench; software would park them here
      sleep_in(SCGC_SM_PDOWN, 1'b1);
      ext_irq <= 1'b1;
      repeat (40) @(posedge hclk);
      check({31'h0, gate_en.cpu}, 32'h0);
      wake(2, PDW + 4, PDW + 10);
      check({vec_miss, resume_cnt}, 16'h0004);
      // a write with the clock enable low must not land
      clk_en <= 1'b0;
      ahb(1'b1, SCGC_ADDR_PCG0, {24'h0, ~seed[7:0]});
      clk_en <= 1'b1;
      ahb(1'b0, SCGC_ADDR_PCG0, 32'h0);
      check(rd, {24'h0, seed[7:0]});
      check({31'h0, hresp}, 32'h0);
      // reset while asleep restarts without a sleep resume
      sleep_in(SCGC_SM_PDOWN, 1'b1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (30) @(posedge hclk);
      check({16'h0, resume_cnt, gate_en}, 32'hff);
      test_done;
   end
endmodule
`default_nettype wire
